// file: hdl/accreg_pkg.sv
// package for the accelerometer i2c target port: offsets, address, counts
// assumes a single ref_clk domain; pins arrive unsynchronised
`default_nettype none
package accreg_pkg;
	localparam logic [6:0] ACC_TARGET_ADDR = 7'h14;
	localparam logic [7:0] ACC_OFF_X_LOW = 8'h00;
	localparam logic [7:0] ACC_OFF_X_HIGH = 8'h01;
	localparam logic [7:0] ACC_OFF_Y_LOW = 8'h02;
	localparam logic [7:0] ACC_OFF_Y_HIGH = 8'h03;
	localparam logic [7:0] ACC_OFF_STATUS = 8'h06;
	localparam logic [7:0] ACC_OFF_DETECT = 8'h07;
	localparam logic [7:0] ACC_OFF_TRIM_A = 8'h08;
	localparam logic [7:0] ACC_OFF_TRIM_B = 8'h09;
	localparam logic [7:0] ACC_OFF_CLKCTL = 8'h0a;
	localparam logic [7:0] ACC_OFF_IDENT = 8'h10;
	// identity value is arbitrary
	localparam logic [7:0] ACC_IDENT_VALUE = 8'h5a;
	localparam logic [7:0] ACC_RESET_BYTE = 8'h00;
	localparam logic [7:0] ACC_CNT_RESET = 8'h00;
	localparam logic [3:0] ACC_BITS_PER_BYTE = 4'h8;
	localparam int ACC_DATA_W = 14;
	localparam logic [5:0] ACC_HIGH_PAD = 6'h00;
endpackage
`default_nettype wire

// file: hdl/accreg_sync.sv
// two-flop synchroniser for one pin level
// assumes the input is asynchronous to clk
`default_nettype none
module accreg_sync (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic pin_in,
	output logic pin_sync
);
	logic meta_q;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= 1'b1;
			pin_sync <= 1'b1;
		end else begin
			meta_q <= pin_in;
			pin_sync <= meta_q;
		end
	end
endmodule
`default_nettype wire

// file: hdl/accreg_regmap.sv
// register map: write-only controls, read mux of results and status
// assumes writes are single-cycle strobes from the serial engine
`default_nettype none
module accreg_regmap
	import accreg_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic wr_stb,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] wr_data,
	input wire logic [13:0] x_accel_value,
	input wire logic [13:0] y_accel_value,
	input wire logic [7:0] status_in,
	output logic [7:0] rd_data,
	output logic [7:0] detection_control,
	output logic [7:0] adc_clock_control
);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			detection_control <= ACC_RESET_BYTE;
			adc_clock_control <= ACC_RESET_BYTE;
		end else if (wr_stb) begin
			if (reg_addr == ACC_OFF_DETECT)
				detection_control <= wr_data;
			if (reg_addr == ACC_OFF_CLKCTL)
				adc_clock_control <= wr_data;
		end
	end
	always_comb begin
		unique case (reg_addr)
			ACC_OFF_X_LOW: rd_data = x_accel_value[7:0];
			ACC_OFF_X_HIGH: rd_data = {2'b00, x_accel_value[13:8]};
			ACC_OFF_Y_LOW: rd_data = y_accel_value[7:0];
			ACC_OFF_Y_HIGH: rd_data = {2'b00, y_accel_value[13:8]};
			ACC_OFF_STATUS: rd_data = status_in;
			ACC_OFF_IDENT: rd_data = ACC_IDENT_VALUE;
			default: rd_data = ACC_RESET_BYTE;
		endcase
	end
	AST_HIGH_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(reg_addr == ACC_OFF_X_HIGH || reg_addr == ACC_OFF_Y_HIGH) |-> rd_data[7:6] == 2'b00)
		else $error("high byte top bits not zero");
	AST_WO_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(reg_addr == ACC_OFF_DETECT || reg_addr == ACC_OFF_TRIM_A) |-> rd_data == 8'h00)
		else $error("write-only read not zero");
	AST_DET_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		wr_stb && reg_addr == ACC_OFF_DETECT |=> detection_control == $past(wr_data))
		else $error("detection write lost");
endmodule
`default_nettype wire

// file: hdl/accreg_i2c_port.sv
// i2c target port of a two-axis sensor, with its register map
// Operation
// - clock pin is input only; never driven.
// - data pin open-drain: only pull low or release.
// - data changes only while clock low.
// - start is data fall, stop is data rise, clock high.
// - idle when both lines high; start opens transfer.
// - msb first, eight data pulses then acknowledge pulse.
// - transmitter releases after eight bits; receiver holds ack low.
// - after master nack, release data for stop or restart.
// - repeated start treated exactly like a fresh start.
// - first byte is seven address bits plus direction bit.
// - acknowledge only the fixed target address.
// - first written byte loads the register address counter.
// - further written bytes stored; counter increments each byte. Here only offsets 0x07 and 0x0a keep a written byte; others are dropped.
// - reads send addressed register, counter increments per byte.
// - x value 14-bit, split over offsets 0 and 1.
// - y value 14-bit, split over offsets 2 and 3.
// - ten user registers of mixed access.
// assumes scl/sda pins are asynchronous; sensor values from ref_clk logic
`default_nettype none
module accreg_i2c_port
	import accreg_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [13:0] x_accel_value,
	input wire logic [13:0] y_accel_value,
	input wire logic [7:0] status_in,
	output logic [7:0] detection_control,
	output logic [7:0] adc_clock_control,
	output logic [7:0] addr_counter,
	output logic bus_busy
);
	typedef enum logic [2:0] {
		ACC_IDLE, ACC_ADDR, ACC_ACK_OUT, ACC_RX, ACC_TX, ACC_ACK_IN
	} accreg_state_t;

	function automatic logic [7:0] accreg_inc(input logic [7:0] v);
		accreg_inc = v + 8'h01;
	endfunction

	logic scl_s, sda_s, scl_d1_q, sda_d1_q;
	logic scl_rise, scl_fall, start_det, stop_det;
	accreg_state_t state_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic rw_q, first_q, ack_q, wr_stb_q;
	logic [7:0] addr_q, rd_data, wr_data_q;
	logic pull_q;

	accreg_sync u_scl_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_in(scl_in),
		.pin_sync(scl_s)
	);
	accreg_sync u_sda_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_in(sda_in),
		.pin_sync(sda_s)
	);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end else begin
			scl_d1_q <= scl_s;
			sda_d1_q <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_d1_q;
	assign scl_fall = !scl_s && scl_d1_q;
	assign start_det = scl_s && scl_d1_q && sda_d1_q && !sda_s;
	assign stop_det = scl_s && scl_d1_q && !sda_d1_q && sda_s;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			bus_busy <= 1'b0;
		else if (start_det)
			bus_busy <= 1'b1;
		else if (stop_det)
			bus_busy <= 1'b0;
	end

	accreg_regmap u_regmap (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.wr_stb(wr_stb_q),
		.reg_addr(addr_q),
		.wr_data(wr_data_q),
		.x_accel_value(x_accel_value),
		.y_accel_value(y_accel_value),
		.status_in(status_in),
		.rd_data(rd_data),
		.detection_control(detection_control),
		.adc_clock_control(adc_clock_control)
	);

	// serial engine; bits sampled on scl rise, driven after scl fall
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ACC_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= ACC_RESET_BYTE;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			ack_q <= 1'b0;
			wr_stb_q <= 1'b0;
			wr_data_q <= ACC_RESET_BYTE;
			addr_q <= ACC_CNT_RESET;
		end else begin
			wr_stb_q <= 1'b0;
			if (start_det) begin
				state_q <= ACC_ADDR;
				bit_cnt_q <= 4'h0;
			end else if (stop_det) begin
				state_q <= ACC_IDLE;
			end else begin
				unique case (state_q)
					ACC_IDLE: ;
					ACC_ADDR, ACC_RX: if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_s};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == ACC_BITS_PER_BYTE) begin
						bit_cnt_q <= 4'h0;
						if (state_q == ACC_ADDR) begin
							rw_q <= shift_q[0];
							first_q <= 1'b1;
							if (shift_q[7:1] == ACC_TARGET_ADDR) begin
								state_q <= ACC_ACK_OUT;
								ack_q <= 1'b1;
							end else begin
								state_q <= ACC_IDLE;
							end
						end else begin
							state_q <= ACC_ACK_OUT;
							ack_q <= 1'b1;
							first_q <= 1'b0;
							if (first_q) begin
								addr_q <= shift_q;
							end else begin
								wr_stb_q <= 1'b1;
								wr_data_q <= shift_q;
							end
						end
					end
					ACC_ACK_OUT: if (scl_fall) begin
						ack_q <= 1'b0;
						if (rw_q && !first_q) begin
							state_q <= ACC_TX;
							shift_q <= rd_data;
							addr_q <= accreg_inc(addr_q);
						end else if (rw_q) begin
							state_q <= ACC_TX;
							first_q <= 1'b0;
							shift_q <= rd_data;
							addr_q <= accreg_inc(addr_q);
						end else begin
							state_q <= ACC_RX;
						end
					end
					ACC_TX: if (scl_rise) begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall) begin
						shift_q <= {shift_q[6:0], 1'b1};
						if (bit_cnt_q == ACC_BITS_PER_BYTE) begin
							bit_cnt_q <= 4'h0;
							state_q <= ACC_ACK_IN;
						end
					end
					ACC_ACK_IN: if (scl_rise) begin
						ack_q <= !sda_s;
					end else if (scl_fall) begin
						if (ack_q) begin
							state_q <= ACC_TX;
							shift_q <= rd_data;
							addr_q <= accreg_inc(addr_q);
						end else begin
							state_q <= ACC_IDLE;
						end
						ack_q <= 1'b0;
					end
					default: state_q <= ACC_IDLE;
				endcase
			end
			// increment after written byte; 8-bit wrap
			if (wr_stb_q)
				addr_q <= accreg_inc(addr_q);
		end
	end

	// open drain pull low only; updated on ref_clk after scl fall
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			pull_q <= 1'b0;
		else if (start_det || stop_det)
			pull_q <= 1'b0;
		else if (state_q == ACC_ACK_OUT)
			pull_q <= ack_q;
		else if (state_q == ACC_TX)
			pull_q <= !shift_q[7];
		else
			pull_q <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			addr_counter <= ACC_CNT_RESET;
		end else begin
			sda_out <= 1'b0;
			sda_oe <= pull_q;
			addr_counter <= addr_q;
		end
	end

	AST_OUT_LOW: assert property (@(posedge ref_clk) disable iff (!reset_n)
		sda_oe |-> !sda_out)
		else $error("data driven high");
	AST_START_ADDR: assert property (@(posedge ref_clk) disable iff (!reset_n)
		start_det |=> state_q == ACC_ADDR && bit_cnt_q == 4'h0)
		else $error("start not restarting address phase");
	AST_NO_MATCH: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state_q == ACC_ADDR && scl_fall && bit_cnt_q == ACC_BITS_PER_BYTE && !start_det && !stop_det
		&& shift_q[7:1] != ACC_TARGET_ADDR |=> state_q == ACC_IDLE)
		else $error("foreign address acknowledged");
	AST_WRAP: assert property (@(posedge ref_clk) disable iff (!reset_n)
		wr_stb_q && addr_q == 8'hff |=> addr_q == 8'h00)
		else $error("counter did not wrap");
	AST_STOP_RELEASE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		stop_det |=> ##1 !sda_oe)
		else $error("data held after stop");
	AST_ACK_DRIVE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state_q == ACC_ACK_OUT && ack_q && !start_det && !stop_det |=> ##1 sda_oe)
		else $error("ack not driven");
endmodule
`default_nettype wire

// file: tb/accreg_master.sv
// behavioural bus master standing on the far side of the target port
// assumes ref_clk at 50 MHz; serial clock is 8 ref_clk cycles, low 6, high 2
`default_nettype none
module accreg_master (
	input wire logic ref_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_pull,
	output logic [7:0] res_val,
	output logic res_stb
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
		res_val = 8'h00;
		res_stb = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// both lines never low together for more than a bit time
	// data moves two cycles after the clock falls, well before it rises
	// one clock pulse per bit, master made
	task automatic clk_bit(input logic drive_low, output logic seen);
		cyc(2);
		sda_pull <= drive_low;
		cyc(4);
		scl <= 1'b1;
		cyc(2);
		seen = sda;
		scl <= 1'b0;
	endtask

	task automatic report(input logic [7:0] v);
		res_val <= v;
		res_stb <= 1'b1;
		@(posedge ref_clk);
		res_stb <= 1'b0;
	endtask

	// data falls while clock high opens a frame
	// the same sequence serves as a repeated start
	task automatic start();
		cyc(2);
		sda_pull <= 1'b0;
		cyc(4);
		scl <= 1'b1;
		cyc(3);
		sda_pull <= 1'b1;
		cyc(3);
		scl <= 1'b0;
	endtask

	// stop after a missing acknowledge or at the end of a transfer
	task automatic stop();
		cyc(2);
		sda_pull <= 1'b1;
		cyc(4);
		scl <= 1'b1;
		cyc(3);
		sda_pull <= 1'b0;
		cyc(8);
	endtask

	// release after eight bits and sample the acknowledge pulse
	task automatic put_byte(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(~b[i], s);
		end
		clk_bit(1'b0, s);
		report({7'h00, s});
	endtask

	// withhold the acknowledge on the last byte read
	task automatic get_byte(input logic last);
		logic s;
		logic [7:0] d;
		d = 8'h00;
		for (int i = 0; i < 8; i++) begin
			clk_bit(1'b0, s);
			d = {d[6:0], s};
		end
		clk_bit(~last, s);
		report(d);
	endtask
endmodule
`default_nettype wire

// file: tb/accel_i2c_slave_register_port_bench.sv
// self-checking bench for the accelerometer serial target port
// assumes the master model in accreg_master.sv; sda is a wired line with pull-up
`default_nettype none
module accel_i2c_slave_register_port_bench import accreg_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic ref_clk, reset_n, scl, sda_pull, sda_oe, sda_out, busy, res_stb;
	logic [13:0] x_val, y_val;
	logic [7:0] st, det, clk_ctl, cnt, res_val, d;
	logic [7:0] exp_q[$];
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	int seed = 32'hcca311a3;
	wire sda_line;

	// device only pulls low; pull-up wins otherwise
	assign sda_line = ~(sda_oe & ~sda_out) & ~sda_pull;

	accreg_i2c_port i_accreg_i2c_port (.ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .x_accel_value(x_val), .y_accel_value(y_val), .status_in(st),
		.detection_control(det), .adc_clock_control(clk_ctl), .addr_counter(cnt), .bus_busy(busy));
	accreg_master i_accreg_master (.ref_clk(ref_clk), .sda(sda_line), .scl(scl), .sda_pull(sda_pull),
		.res_val(res_val), .res_stb(res_stb));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	function automatic logic [7:0] exp_reg(input logic [7:0] a);
		case (a)
			ACC_OFF_X_LOW: return x_val[7:0];
			ACC_OFF_X_HIGH: return {2'b00, x_val[13:8]};
			ACC_OFF_Y_LOW: return y_val[7:0];
			ACC_OFF_Y_HIGH: return {2'b00, y_val[13:8]};
			ACC_OFF_STATUS: return st;
			ACC_OFF_IDENT: return ACC_IDENT_VALUE;
			default: return 8'h00;
		endcase
	endfunction

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ack results read 0, a refusal 1
	task automatic wr_byte(input logic [7:0] b, input logic nack);
		exp_q.push_back({7'h00, nack});
		i_accreg_master.put_byte(b);
	endtask

	task automatic rd_byte(input logic [7:0] a, input logic last);
		exp_q.push_back(exp_reg(a));
		i_accreg_master.get_byte(last);
	endtask

	always @(posedge ref_clk) begin
		if (res_stb) begin
			if (exp_q.size() == 0)
				check("unsolicited result", 8'hee, res_val);
			else
				check("bus byte", exp_q.pop_front(), res_val);
		end
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			stop_test();
		end
	end

	initial begin
		reset_n = 1'b0;
		x_val = 14'h0000;
		y_val = 14'h0000;
		st = 8'h00;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check("detection_control", 8'h00, det);
		check("addr_counter", ACC_CNT_RESET, cnt);
		$display("test reset done");
		d = 8'($random(seed));
		i_accreg_master.start();
		wr_byte({ACC_TARGET_ADDR, 1'b0}, 1'b0);
		wr_byte(ACC_OFF_DETECT, 1'b0);
		wr_byte(d, 1'b0);
		wr_byte(8'h0f, 1'b0);
		check("bus_busy", 8'h01, {7'h00, busy});
		wr_byte(8'h0f, 1'b0);
		wr_byte(d ^ 8'h5a, 1'b0);
		i_accreg_master.stop();
		check("detection_control", d, det);
		check("adc_clock_control", d ^ 8'h5a, clk_ctl);
		check("addr_counter", 8'h0b, cnt);
		check("bus_busy", 8'h00, {7'h00, busy});
		$display("test write done");
		i_accreg_master.start();
		wr_byte({ACC_TARGET_ADDR ^ 7'h01, 1'b0}, 1'b1);
		i_accreg_master.stop();
		check("addr_counter", 8'h0b, cnt);
		$display("test foreign address done");
		@(posedge ref_clk);
		x_val <= 14'($random(seed));
		y_val <= 14'($random(seed));
		st <= 8'($random(seed));
		// address write, then restart with read
		i_accreg_master.start();
		wr_byte({ACC_TARGET_ADDR, 1'b0}, 1'b0);
		wr_byte(ACC_OFF_X_LOW, 1'b0);
		i_accreg_master.start();
		wr_byte({ACC_TARGET_ADDR, 1'b1}, 1'b0);
		for (int a = 0; a <= 16; a++) begin
			rd_byte(8'(a), a == 16);
		end
		i_accreg_master.stop();
		check("addr_counter", 8'h11, cnt);
		check("bus_busy", 8'h00, {7'h00, busy});
		$display("test register read done");
		i_accreg_master.start();
		wr_byte({ACC_TARGET_ADDR, 1'b0}, 1'b0);
		wr_byte(8'hff, 1'b0);
		wr_byte(8'h33, 1'b0);
		i_accreg_master.stop();
		check("addr_counter", 8'h00, cnt);
		i_accreg_master.start();
		wr_byte({ACC_TARGET_ADDR, 1'b1}, 1'b0);
		rd_byte(ACC_OFF_X_LOW, 1'b1);
		i_accreg_master.stop();
		check("addr_counter", 8'h01, cnt);
		$display("test wrap done");
		repeat (4) @(posedge ref_clk);
		check("pending results", 8'h00, 8'(exp_q.size()));
		stop_test();
	end
endmodule
`default_nettype wire
